// File: rtl/papc_pkg.sv
// papc_pkg: register map, field positions and reset values of the port A
// override and pull-up control block; assumes a 32-bit Avalon-MM word bus.
package papc_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_PIN_IN    = 5'h00;
  localparam logic [4:0] OFS_PIN_DIR   = 5'h04;
  localparam logic [4:0] OFS_PIN_OUT   = 5'h08;
  localparam logic [4:0] OFS_MCU_CTRL  = 5'h0C;
  localparam logic [4:0] OFS_PORT_CTRL = 5'h10;

  // mcu_control fields
  localparam int MCU_PUD_BIT   = 4;
  localparam int MCU_BODSE_BIT = 5;
  localparam int MCU_BODS_BIT  = 6;
  localparam logic [7:0] MCU_CTRL_MASK  = 8'h70;
  localparam logic [7:0] MCU_CTRL_RESET = 8'h00;

  // port_control fields (port A uses index 0, second port index 1)
  localparam int PC_PUD_A_BIT = 0;
  localparam int PC_PUD_B_BIT = 1;
  localparam int PC_BBM_A_BIT = 4;
  localparam int PC_BBM_B_BIT = 5;
  localparam logic [7:0] PORT_CTRL_MASK  = 8'h33;
  localparam logic [7:0] PORT_CTRL_RESET = 8'h00;

  // pin register reset values
  localparam logic [7:0] PIN_DIR_RESET = 8'h00;
  localparam logic [7:0] PIN_OUT_RESET = 8'h00;

  // pin positions of alternate functions
  localparam int PIN_MISO = 2;
  localparam int PIN_MOSI = 4;
  localparam int PIN_SCK  = 5;
  localparam int PIN_SSEL = 6;
  localparam int PIN_REF  = 7;
endpackage : papc_pkg

// File: rtl/papc_port_a.sv
// papc_port_a: pull-up control and alternate-function override of port A,
// with its direction, output and control registers on an Avalon-MM slave.
// assumes peripheral controls come from logic on clk; pins are asynchronous.
//
// Summary of operation
// - global pull-up disable bit forces every port pull-up off.
// - break-before-make inserts one tri-state cycle when a pin turns output.
// - port-wise pull-up disable turns off all pull-ups of that port.
// - effective pull-up disable is port-wise bit OR global bit.
// - reference output with internal reference disables pin 7 pull-up and driver.
// - external reference or bypass use disables pin 7 pull-up and driver.
// - SPI slave forces pin 6 slave select to input.
// - slave SPI active only while external master holds select low.
// - SPI master leaves pin 6 direction to its direction bit.
// - SPI slave forces pin 5 serial clock to input.
// - SPI master leaves pin 5 direction to its direction bit.
// - pins forced to input by SPI keep pull-up from output bit.
// - pin 4 forced input as slave, follows its direction bit as master.
// - three-wire data output replaces pin 2 value unless SPI slave, driven only when direction one.
// - pin 2 input in three-wire mode keeps pull-up from output bit.
// - SPI master forces pin 2 to input.
// - SPI slave leaves pin 2 direction to its direction bit.
// - default pull-up on when direction zero, output one, disable zero.
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module papc_port_a (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // peripheral controls
  input  wire logic        spi_en,
  input  wire logic        spi_master,
  input  wire logic        spi_sck_out,
  input  wire logic        spi_mosi_out,
  input  wire logic        spi_miso_out,
  input  wire logic        usi_three_wire,
  input  wire logic        usi_data_out,
  input  wire logic        timer0_compare_en,
  input  wire logic        timer0_compare_out,
  input  wire logic        ref_output_en,
  input  wire logic        adc_ref_internal,
  input  wire logic        ext_ref_input,
  // pins
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe,
  output logic      [7:0]  pin_pullup,
  // peripheral side
  input  wire logic        spi_slave_active_dummy,
  output logic      [7:0]  pin_level,
  output logic             spi_slave_active,
  output logic             portb_pullup_off,
  output logic             bod_sleep,
  output logic             bod_sleep_en
);

  // registers
  logic [7:0]  pin_dir_bit_ff;
  logic [7:0]  pin_out_bit_ff;
  logic [7:0]  dir_q_ff;
  logic [7:0]  mcu_control_ff;
  logic [7:0]  port_control_ff;
  logic [7:0]  sync1_ff;
  logic [7:0]  sync2_ff;
  logic [7:0]  sync3_ff;
  logic [7:0]  pin_level_ff;
  logic [7:0]  pin_out_ff;
  logic [7:0]  pin_oe_ff;
  logic [7:0]  pin_pullup_ff;
  logic [31:0] readdata_ff;
  logic        waitrequest_ff;
  logic        slave_active_ff;
  logic        portb_off_ff;

  // pull-up when input, output bit one and not disabled
  function automatic logic [7:0] pullup_calc(input logic [7:0] oe, input logic [7:0] val,
                                             input logic off);
    pullup_calc = ~oe & val & {8{~off}};
  endfunction : pullup_calc

  // bus decode
  wire       req        = avs_read | avs_write;
  wire       take       = req & waitrequest_ff;
  wire       wr_commit  = avs_write & ~waitrequest_ff & avs_byteenable[0];
  wire       sel_in     = (avs_address == papc_pkg::OFS_PIN_IN);
  wire       sel_dir    = (avs_address == papc_pkg::OFS_PIN_DIR);
  wire       sel_out    = (avs_address == papc_pkg::OFS_PIN_OUT);
  wire       sel_mcu    = (avs_address == papc_pkg::OFS_MCU_CTRL);
  wire       sel_pc     = (avs_address == papc_pkg::OFS_PORT_CTRL);
  wire [7:0] wbyte      = avs_writedata[7:0];
  wire [7:0] rd_byte    = sel_in  ? pin_level_ff :
                          sel_dir ? pin_dir_bit_ff :
                          sel_out ? pin_out_bit_ff :
                          sel_mcu ? mcu_control_ff :
                          sel_pc  ? port_control_ff : 8'h00;
  wire       nxt_waitrequest = ~take;

  // pull-up disables
  wire       pullup_off = mcu_control_ff[papc_pkg::MCU_PUD_BIT]
                        | port_control_ff[papc_pkg::PC_PUD_A_BIT];
  wire       pb_off     = mcu_control_ff[papc_pkg::MCU_PUD_BIT]
                        | port_control_ff[papc_pkg::PC_PUD_B_BIT];
  wire       bbm_en     = port_control_ff[papc_pkg::PC_BBM_A_BIT];

  // peripheral modes
  wire       spi_slv    = spi_en & ~spi_master;
  wire       spi_mst    = spi_en & spi_master;
  wire       ref_off    = (ref_output_en & adc_ref_internal)
                        | ext_ref_input;

  // direction after overrides; master leaves pins 6,5,4 to their bits
  wire [7:0] force_in;
  assign force_in[papc_pkg::PIN_SSEL] = spi_slv;
  assign force_in[papc_pkg::PIN_SCK]  = spi_slv;
  assign force_in[papc_pkg::PIN_MOSI] = spi_slv;
  assign force_in[papc_pkg::PIN_MISO] = spi_mst;
  assign force_in[papc_pkg::PIN_REF]  = ref_off;
  assign force_in[3]                  = 1'b0;
  assign force_in[1:0]                = 2'b00;
  wire [7:0] dir_eff    = pin_dir_bit_ff & ~force_in;

  // break-before-make: hold tri-state one cycle on a rising direction bit
  wire [7:0] dir_rise   = pin_dir_bit_ff & ~dir_q_ff;
  wire [7:0] nxt_oe     = dir_eff & ~({8{bbm_en}} & dir_rise);

  // driven value with peripheral substitution
  wire       miso_val   = spi_slv        ? spi_miso_out :
                          usi_three_wire ? usi_data_out :
                          timer0_compare_en ? timer0_compare_out :
                          pin_out_bit_ff[papc_pkg::PIN_MISO];
  wire [7:0] val_eff;
  assign val_eff[7:6]              = pin_out_bit_ff[7:6];
  assign val_eff[papc_pkg::PIN_SCK]  = spi_mst ? spi_sck_out : pin_out_bit_ff[5];
  assign val_eff[papc_pkg::PIN_MOSI] = spi_mst ? spi_mosi_out : pin_out_bit_ff[4];
  assign val_eff[3]                = pin_out_bit_ff[3];
  assign val_eff[papc_pkg::PIN_MISO] = miso_val;
  assign val_eff[1:0]              = pin_out_bit_ff[1:0];

  // pull-up from the output bit, also on forced inputs; off on reference pin
  wire [7:0] pull_raw   = pullup_calc(dir_eff, pin_out_bit_ff, pullup_off);
  wire [7:0] nxt_pullup = pull_raw & ~{ref_off, 7'h00};

  // slave select sampled low while slave enabled
  wire       nxt_slave_active = spi_slv & ~pin_level_ff[papc_pkg::PIN_SSEL];

  // pin input synchroniser, change taken when stages two and three agree
  wire [7:0] nxt_level  = (sync2_ff & sync3_ff) | (pin_level_ff & (sync2_ff | sync3_ff));

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1_ff     <= 8'h00;
      sync2_ff     <= 8'h00;
      sync3_ff     <= 8'h00;
      pin_level_ff <= 8'h00;
    end else begin
      sync1_ff     <= pin_in;
      sync2_ff     <= sync1_ff;
      sync3_ff     <= sync2_ff;
      pin_level_ff <= nxt_level;
    end
  end

  // software registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_dir_bit_ff  <= papc_pkg::PIN_DIR_RESET;
      pin_out_bit_ff  <= papc_pkg::PIN_OUT_RESET;
      mcu_control_ff  <= papc_pkg::MCU_CTRL_RESET;
      port_control_ff <= papc_pkg::PORT_CTRL_RESET;
    end else if (wr_commit) begin
      if (sel_dir) pin_dir_bit_ff <= wbyte;
      if (sel_out) pin_out_bit_ff <= wbyte;
      if (sel_mcu) mcu_control_ff <= wbyte & papc_pkg::MCU_CTRL_MASK;
      if (sel_pc)  port_control_ff <= wbyte & papc_pkg::PORT_CTRL_MASK;
    end
  end

  // bus answer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      waitrequest_ff <= 1'b1;
      readdata_ff    <= 32'h0000_0000;
    end else begin
      waitrequest_ff <= nxt_waitrequest;
      if (take && avs_read) readdata_ff <= {24'h00_0000, rd_byte};
    end
  end

  // pin drive
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dir_q_ff        <= 8'h00;
      pin_oe_ff       <= 8'h00;
      pin_out_ff      <= 8'h00;
      pin_pullup_ff   <= 8'h00;
      slave_active_ff <= 1'b0;
      portb_off_ff    <= 1'b0;
    end else begin
      dir_q_ff        <= pin_dir_bit_ff;
      pin_oe_ff       <= nxt_oe;
      pin_out_ff      <= val_eff;
      pin_pullup_ff   <= nxt_pullup;
      slave_active_ff <= nxt_slave_active;
      portb_off_ff    <= pb_off;
    end
  end

  assign avs_readdata     = readdata_ff;
  assign avs_waitrequest  = waitrequest_ff;
  assign pin_out          = pin_out_ff;
  assign pin_oe           = pin_oe_ff;
  assign pin_pullup       = pin_pullup_ff;
  assign pin_level        = pin_level_ff;
  assign spi_slave_active = slave_active_ff;
  assign portb_pullup_off = portb_off_ff;
  assign bod_sleep        = mcu_control_ff[papc_pkg::MCU_BODS_BIT];
  assign bod_sleep_en     = mcu_control_ff[papc_pkg::MCU_BODSE_BIT];

endmodule : papc_port_a

// File: tb/papc_pins.sv
// papc_pins: board wired to the port pins, with external sources.
// assumes pin_oe high means the device drives the pin.
`timescale 1ns/100ps
module papc_pins (
  // clock
  input logic        clk,
  // device side
  input logic  [7:0] pin_out,
  input logic  [7:0] pin_oe,
  input logic  [7:0] pin_pullup,
  // external sources
  input logic  [7:0] ext_en,
  input logic  [7:0] ext_val,
  // pin levels
  output logic [7:0] pin_in
);
  logic [7:0] float_ff = 8'h55;
  always_ff @(posedge clk) float_ff <= ~float_ff;
  // external master holds select low to activate a slave
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & (pin_pullup | float_ff));
endmodule : papc_pins

// File: tb/papc_port_a_checker.sv
// papc_port_a_checker: port-level assertions for papc_port_a.
// assumes one clock domain clk with synchronous active-low rstn.
`timescale 1ns/100ps
module papc_port_a_checker (
  // clock and reset
  input logic       clk,
  input logic       rstn,
  // bus
  input logic       avs_read,
  input logic       avs_write,
  input logic       avs_waitrequest,
  // peripheral controls
  input logic       spi_en,
  input logic       spi_master,
  input logic       spi_sck_out,
  input logic       usi_three_wire,
  input logic       usi_data_out,
  input logic       ref_output_en,
  input logic       adc_ref_internal,
  input logic       ext_ref_input,
  // pins
  input logic [7:0] pin_out,
  input logic [7:0] pin_oe,
  input logic [7:0] pin_pullup,
  input logic       spi_slave_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request left unanswered");
  slave_input_a: assert property (spi_en && !spi_master |=> pin_oe[6:4] == 3'h0)
    else $error("spi slave pins still driven");
  miso_input_a: assert property (spi_en && spi_master |=> !pin_oe[2])
    else $error("spi master input pin driven");
  ref_pin_off_a: assert property ((ref_output_en && adc_ref_internal) || ext_ref_input
    |=> !pin_oe[7] && !pin_pullup[7]) else $error("reference pin not released");
  pull_drive_excl_a: assert property ((pin_pullup & pin_oe) == 8'h00)
    else $error("pull-up on a driven pin");
  sck_value_a: assert property (spi_en && spi_master ##1 pin_oe[5]
    |-> pin_out[5] == $past(spi_sck_out)) else $error("serial clock value wrong");
  usi_value_a: assert property (usi_three_wire && !spi_en ##1 pin_oe[2]
    |-> pin_out[2] == $past(usi_data_out)) else $error("three-wire data value wrong");
  slave_active_a: assert property (spi_slave_active |-> $past(spi_en && !spi_master))
    else $error("slave active outside slave mode");
endmodule : papc_port_a_checker

bind papc_port_a papc_port_a_checker chk_i (.clk, .rstn, .avs_read, .avs_write,
  .avs_waitrequest, .spi_en, .spi_master, .spi_sck_out, .usi_three_wire, .usi_data_out,
  .ref_output_en, .adc_ref_internal, .ext_ref_input, .pin_out, .pin_oe, .pin_pullup,
  .spi_slave_active);

// File: tb/tb_papc_port_a.sv
// tb_papc_port_a: self-checking bench for papc_port_a.
// assumes papc_pins stands for the board on the port pins.
`timescale 1ns/100ps
module tb_papc_port_a;
  logic clk = 0, rstn = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic spi_en = 0, spi_master = 0, spi_sck_out = 0, spi_mosi_out = 0, spi_miso_out = 0;
  logic usi_three_wire = 0, usi_data_out = 0, timer0_compare_en = 0, timer0_compare_out = 0;
  logic ref_output_en = 0, adc_ref_internal = 0, ext_ref_input = 0, spi_slave_active;
  logic portb_pullup_off, q, bod_sleep, bod_sleep_en;
  logic [7:0] pin_level;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, ext_en = 8'h00, ext_val = 8'h00, r;
  int num_errors = 0, num_checks = 0;
  always #12.5 clk = ~clk;
  papc_port_a dut (.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .spi_en, .spi_master,
    .spi_sck_out, .spi_mosi_out, .spi_miso_out, .usi_three_wire, .usi_data_out,
    .timer0_compare_en, .timer0_compare_out, .ref_output_en, .adc_ref_internal,
    .ext_ref_input, .pin_in, .pin_out, .pin_oe, .pin_pullup, .spi_slave_active_dummy(1'b0),
    .pin_level, .spi_slave_active, .portb_pullup_off, .bod_sleep, .bod_sleep_en);
  papc_pins brd (.clk, .pin_out, .pin_oe, .pin_pullup, .ext_en, .ext_val, .pin_in);
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      num_errors++;
      complete_run();
    end
    r = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic per(input logic [11:0] v);
    @(posedge clk);
    {spi_en, spi_master, spi_sck_out, spi_mosi_out, spi_miso_out, usi_three_wire,
     usi_data_out, timer0_compare_en, timer0_compare_out, ref_output_en, adc_ref_internal,
     ext_ref_input} <= v;
    @(posedge clk);
    #1;
  endtask : per
  task automatic t_regs();
    bus(0, papc_pkg::OFS_MCU_CTRL, 8'h00); chk("mcu", r, papc_pkg::MCU_CTRL_RESET);
    bus(0, papc_pkg::OFS_PORT_CTRL, 8'h00); chk("pcr", r, papc_pkg::PORT_CTRL_RESET);
    bus(1, papc_pkg::OFS_MCU_CTRL, 8'hFF);
    bus(0, papc_pkg::OFS_MCU_CTRL, 8'h00); chk("mcu", r, 8'h70);
    chk("bod", {6'h00, bod_sleep, bod_sleep_en}, 8'h03);
    bus(1, papc_pkg::OFS_MCU_CTRL, 8'h00);
    bus(1, 5'h14, 8'hFF);
    bus(0, 5'h14, 8'h00); chk("unmapped", r, 8'h00);
  endtask : t_regs
  task automatic t_pull();
    bus(1, papc_pkg::OFS_PIN_OUT, 8'hFF);
    per(12'h000); chk("pull", pin_pullup, 8'hFF);
    bus(1, papc_pkg::OFS_MCU_CTRL, 8'h10);
    per(12'h000); chk("pull", pin_pullup, 8'h00);
    chk("pbo", {7'h00, portb_pullup_off}, 8'h01);
    bus(1, papc_pkg::OFS_MCU_CTRL, 8'h00);
    bus(1, papc_pkg::OFS_PORT_CTRL, 8'h01);
    per(12'h000); chk("pull", pin_pullup, 8'h00);
    bus(1, papc_pkg::OFS_PORT_CTRL, 8'h02);
    per(12'h000); chk("pull", pin_pullup, 8'hFF);
  endtask : t_pull
  task automatic t_bbm();
    bus(1, papc_pkg::OFS_PORT_CTRL, 8'h10);
    bus(1, papc_pkg::OFS_PIN_DIR, 8'h01);
    @(posedge clk); #1 chk("oe", pin_oe, 8'h00);
    @(posedge clk); #1 chk("oe", pin_oe, 8'h01);
    bus(1, papc_pkg::OFS_PORT_CTRL, 8'h00);
    bus(1, papc_pkg::OFS_PIN_DIR, 8'h00);
    bus(1, papc_pkg::OFS_PIN_DIR, 8'h01);
    @(posedge clk); #1 chk("oe", pin_oe, 8'h01);
  endtask : t_bbm
  task automatic t_spi();
    bus(1, papc_pkg::OFS_PIN_DIR, 8'hFF);
    per(12'h800); chk("oe", pin_oe, 8'h8F);
    chk("pull", pin_pullup, 8'h70); chk("out", pin_out & 8'h8F, 8'h8B);
    ext_en <= 8'h40;
    for (int i = 0; i < 2; i++) begin
      ext_val <= {1'b0, i[0], 6'h00};
      for (int n = 0; n < 12 && spi_slave_active !== !i[0]; n++) @(posedge clk);
      chk("active", {7'h00, spi_slave_active}, {7'h00, !i[0]});
      chk("level6", {7'h00, pin_level[6]}, {7'h00, i[0]});
    end
    per(12'hE00); chk("oe", pin_oe, 8'hFB);
    chk("pull", pin_pullup, 8'h04); chk("out", pin_out & 8'hFB, 8'hEB);
  endtask : t_spi
  task automatic t_alt();
    for (int i = 0; i < 3; i++) begin
      per(i == 0 ? 12'h006 : i == 1 ? 12'h001 : 12'h004);
      chk("p7", {pin_oe[7], pin_pullup[7]}, i == 2 ? 8'h02 : 8'h00);
    end
    bus(1, papc_pkg::OFS_PIN_DIR, 8'h04);
    bus(1, papc_pkg::OFS_PIN_OUT, 8'h00);
    per(12'h060); chk("out", pin_out & 8'h04, 8'h04);
    per(12'h018); chk("out", pin_out & 8'h04, 8'h04);
    bus(1, papc_pkg::OFS_PIN_DIR, 8'h00);
    bus(1, papc_pkg::OFS_PIN_OUT, 8'h04);
    per(12'h060); chk("pull", pin_pullup | pin_oe, 8'h04);
  endtask : t_alt
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_pull();
    t_bbm();
    t_spi();
    t_alt();
    complete_run();
  end
endmodule : tb_papc_port_a
